// file: sim/periph_model.sv
`timescale 1ns/1ns
// ==========================================================
// Peripherals beside the core: raise wake requests on command
module periph_model
  import sleep_ctrl_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] req,
  output sleep_ctrl_pkg::wake_src_t wake_src,
  output logic [7:0] ext_lines_n
);
  // Registered so requests move just after an edge, like a real source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_src <= '0;
      ext_lines_n <= 8'hFF;
    end else begin
      wake_src <= '{two_wire_address_match: (req == 2'd1), other_io: (req == 2'd3),
                    default: 1'b0};
      // Lines idle high as if pulled up; line 4 falls with the other I/O request
      ext_lines_n <= {3'h7, ~(req == 2'd3), 3'h7, ~(req == 2'd2)};
    end
  end
endmodule // periph_model

// file: sim/sleep_ctrl_tb_top.sv
`timescale 1ns/1ns
module sleep_ctrl_tb_top;
  import sleep_ctrl_pkg::*;
  localparam int SU[4] = '{6, 8, 10, 12};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sleep_instr, xtal;
  logic [7:0] paddr, ext_n;
  logic [31:0] pwdata, prdata;
  logic [3:0] csf;
  logic dbg, scan_en, bod, wdt, adc_start, tap_sh, tap_d;
  logic sleeping, ibuf, adc_pwr, adc_ext, comp_pwr, ref_pwr, ref_rdy, bod_act, wdt_act;
  logic jtag_en, tdo, tdo_oe;
  logic [1:0] req;
  wake_src_t wake;
  clk_gate_t gates;
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;

  sleep_ctrl #(.STARTUP_CYC0(SU[0]), .STARTUP_CYC1(SU[1]), .STARTUP_CYC2(SU[2]),
    .STARTUP_CYC3(SU[3])) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_instr(sleep_instr),
    .crystal_clock_option(xtal), .clock_source_select_fuses(csf),
    .debug_enable_fuse(dbg), .scan_port_enable_fuse(scan_en), .brownout_enable_fuse(bod),
    .watchdog_enable(wdt), .external_interrupt_lines_n(ext_n), .ext_int_enable(8'h11),
    .ext_int_level_mode(4'h0), .wake_src(wake), .adc_conv_start(adc_start),
    .tap_shifting(tap_sh), .tap_tdo_data(tap_d), .clk_gates(gates), .sleeping(sleeping),
    .input_buffer_en(ibuf), .adc_power(adc_pwr), .adc_extended_next(adc_ext),
    .comparator_power(comp_pwr), .ref_power(ref_pwr), .ref_ready(ref_rdy),
    .bod_active(bod_act), .wdt_active(wdt_act), .jtag_enable(jtag_en), .tdo_o(tdo),
    .tdo_oe(tdo_oe));
  periph_model partner (.pclk(pclk), .presetn(presetn), .req(req), .wake_src(wake),
    .ext_lines_n(ext_n));

  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  // Hang guard: normal run is far below this
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end

  // ==========================================================
  // Compare and bus tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic chk_n(input int g, input int e, input string s);
    checked++;
    if (g != e) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %0d exp %0d", $time, s, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Request held until the edge at which pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    logic got;
    got = 0;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    while (!got) begin
      #1;
      got = (pready === 1'b1);
      rd = prdata;
      er = pslverr;
      @(posedge pclk);
    end
    psel <= 0;
    penable <= 0;
  endtask

  // ==========================================================
  // Reference model of gating and wake delay
  function automatic logic [6:0] exp_gates(logic [2:0] m, logic as, logic dg);
    case (m)
      MODE_IDLE: return {6'b001111, as};
      MODE_NOISE: return {6'b000111, as};
      MODE_PDOWN: return {5'b0, dg, 1'b0};
      MODE_PSAVE: return {4'b0, as, dg, as};
      MODE_STBY: return 7'b0000010;
      default: return {4'b0, as, 1'b1, as};
    endcase
  endfunction
  function automatic int exp_delay(logic [2:0] m, logic dg, int fs);
    if (m <= MODE_NOISE) return IDLE_WAKE_CYCLES;
    if (m >= MODE_STBY || dg) return STBY_WAKE_CYCLES;
    return SU[fs];
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] rd;
    logic er, as, adc;
    logic [2:0] m;
    logic [6:0] eg;
    int d, n, fs;
    logic [2:0] modes[$] = '{MODE_IDLE, MODE_NOISE, MODE_PDOWN, MODE_PSAVE, MODE_STBY,
                            MODE_XSTBY, MODE_PDOWN};
    {presetn, psel, penable, pwrite, sleep_instr, dbg, bod, wdt, adc_start} = '0;
    {tap_sh, tap_d, paddr, pwdata, csf, req} = '0;
    {xtal, scan_en} = 2'b11;
    void'($urandom(32'h56fa));
    repeat (20) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    #1;
    chk(32'(gates), 32'h7E, "reset gates");
    chk(adc_ext, 1, "reset extended");
    apb(0, CTRL_OFFSET, 0, rd, er);
    chk(rd, 0, "ctrl reset");
    apb(1, CTRL_OFFSET, 32'hFFFF_FE40, rd, er);
    apb(0, CTRL_OFFSET, 0, rd, er);
    chk(rd, 32'h40, "ctrl readback");
    apb(0, 8'h08, 0, rd, er);
    chk({rd[30:0], er}, 1, "unmapped");
    apb(1, STATUS_OFFSET, 32'h1, rd, er);
    chk(er, 1, "status write");
    // Converter restart forces a long first conversion
    @(posedge pclk);
    adc_start <= 1;
    @(posedge pclk);
    adc_start <= 0;
    #1;
    chk(adc_ext, 0, "ext after conv");
    apb(1, CTRL_OFFSET, 0, rd, er);
    apb(1, CTRL_OFFSET, 32'h40, rd, er);
    repeat (2) @(posedge pclk);
    #1;
    chk(adc_ext, 1, "ext after reenable");
    chk(jtag_en, 1, "scan on");
    chk(tdo_oe, 0, "tdo idle float");
    @(posedge pclk);
    tap_sh <= 1;
    tap_d <= 1'($urandom);
    repeat (2) @(posedge pclk);
    #1;
    chk({tdo_oe, tdo}, {1'b1, tap_d}, "tdo shift");
    @(posedge pclk);
    tap_sh <= 0;
    apb(1, CTRL_OFFSET, 32'h10, rd, er);
    repeat (2) @(posedge pclk);
    #1;
    chk(jtag_en, 0, "scan disable bit");
    apb(1, CTRL_OFFSET, 0, rd, er);
    scan_en <= 0;
    repeat (2) @(posedge pclk);
    #1;
    chk(jtag_en, 0, "scan fuse off");
    @(posedge pclk);
    scan_en <= 1;
    for (int i = 0; i < 7; i++) begin
      m = modes[i];
      as = 1'($urandom);
      adc = (i == 3) ? 1'b0 : 1'($urandom);
      fs = $urandom_range(3);
      @(posedge pclk);
      bod <= 1'($urandom);
      wdt <= 1'($urandom);
      dbg <= (i == 6);
      csf <= {fs[1:0], 2'b00};
      // Comparator off before noise reduction, else on without reference; deep modes cut it
      apb(1, CTRL_OFFSET, {23'h0, 1'b0, m != MODE_NOISE, adc, as, 2'b01, m}, rd, er);
      repeat (2) @(posedge pclk);
      sleep_instr <= 1;
      @(posedge pclk);
      sleep_instr <= 0;
      #1;
      eg = exp_gates(m, as, i == 6);
      chk(sleeping, 1, "asleep");
      chk(32'(gates), 32'(eg), "sleep gates");
      chk(ibuf, eg[4] | eg[3], "input buffers");
      chk(adc_pwr, adc, "adc kept");
      chk(comp_pwr, m == MODE_IDLE, "comparator");
      chk(ref_pwr, bod | adc, "reference");
      chk({bod_act, wdt_act}, {bod, wdt}, "bod wdt");
      if (m != MODE_IDLE) begin
        @(posedge pclk);
        req <= 3;
        repeat (8) @(posedge pclk);
        #1;
        chk(sleeping, 1, "other io refused");
      end
      @(posedge pclk);
      req <= (i % 2) ? 2'd2 : 2'd1;
      n = 0;
      do begin
        @(posedge pclk);
        #1;
        n++;
      end while (sleeping !== 1'b0 && n < 40);
      d = 0;
      while (gates.cpu !== 1'b1 && d < 20) begin
        @(posedge pclk);
        req <= 0;
        #1;
        d++;
      end
      chk_n(d, exp_delay(m, i == 6, fs), "wake delay");
      chk(32'(gates), {6'h3F, as}, "gates restored");
      chk(ibuf, 1, "buffers restored");
    end
    apb(1, CTRL_OFFSET, 32'h40, rd, er);
    repeat (REF_STARTUP_CYCLES + 5) @(posedge pclk);
    #1;
    chk(ref_rdy, 1, "reference ready");
    end_of_test();
  end
endmodule // sleep_ctrl_tb_top

// file: src/sleep_ctrl.sv
`timescale 1ns/1ns
module sleep_ctrl #(
  parameter int STARTUP_CYC0 = 6,
  parameter int STARTUP_CYC1 = 1024,
  parameter int STARTUP_CYC2 = 16384,
  parameter int STARTUP_CYC3 = 65536
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sleep_ctrl_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_instr,
  input wire logic crystal_clock_option,
  input wire logic [3:0] clock_source_select_fuses,
  input wire logic debug_enable_fuse,
  input wire logic scan_port_enable_fuse,
  input wire logic brownout_enable_fuse,
  input wire logic watchdog_enable,
  input wire logic [7:0] external_interrupt_lines_n,
  input wire logic [7:0] ext_int_enable,
  input wire logic [3:0] ext_int_level_mode,
  input wire sleep_ctrl_pkg::wake_src_t wake_src,
  input wire logic adc_conv_start,
  input wire logic tap_shifting,
  input wire logic tap_tdo_data,
  output sleep_ctrl_pkg::clk_gate_t clk_gates,
  output logic sleeping,
  output logic input_buffer_en,
  output logic adc_power,
  output logic adc_extended_next,
  output logic comparator_power,
  output logic ref_power,
  output logic ref_ready,
  output logic bod_active,
  output logic wdt_active,
  output logic jtag_enable,
  output logic tdo_o,
  output logic tdo_oe
);
  import sleep_ctrl_pkg::*;

  typedef enum logic [1:0] {ST_ACTIVE, ST_SLEEP, ST_WAKE} state_t;

  // ==========================================================
  // Decode functions
  function automatic clk_gate_t gates_for(input state_t st, input logic [2:0] m,
                                          input logic as0, input logic dbg);
    clk_gate_t g;
    g = '0;
    if (st == ST_ACTIVE) begin // Domains stay gated through the wake delay
      g = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1, main_osc: 1'b1,
            timer_osc: as0};
    end else begin
      unique case (m)
        MODE_IDLE: g = '{cpu: 1'b0, flash: 1'b0, io: 1'b1, adc: 1'b1, asy: 1'b1,
                         main_osc: 1'b1, timer_osc: as0};
        MODE_NOISE: g = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, adc: 1'b1, asy: 1'b1,
                          main_osc: 1'b1, timer_osc: as0};
        MODE_PDOWN: g.main_osc = dbg;
        MODE_PSAVE: g = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, adc: 1'b0, asy: as0,
                          main_osc: dbg, timer_osc: as0};
        MODE_STBY: g.main_osc = 1'b1;
        MODE_XSTBY: g = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, adc: 1'b0, asy: as0,
                          main_osc: 1'b1, timer_osc: as0};
        default: g = '0;
      endcase
    end
    return g;
  endfunction

  function automatic logic deep_mode(input logic [2:0] m);
    return (m != MODE_IDLE) && (m != MODE_NOISE);
  endfunction

  // ==========================================================
  // Registers
  logic [CTRL_W-1:0] ctrl_reg;
  state_t state_reg, state_next;
  logic [2:0] mode_reg, mode_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [7:0] ext_s1_reg, ext_s2_reg, ext_s3_reg, ext_filt_reg;
  logic [CNT_W-1:0] ref_cnt_reg;
  logic adc_en_prev_reg;

  wire [2:0] mode_sel = ctrl_reg[CTRL_MODE_LSB +: 3];
  wire sleep_en = ctrl_reg[CTRL_SLEEP_EN_BIT];
  wire as0 = ctrl_reg[CTRL_ASYNC_SEL_BIT];
  wire adc_en = ctrl_reg[CTRL_ADC_EN_BIT];
  wire comp_en = ctrl_reg[CTRL_COMP_EN_BIT];
  wire comp_ref = ctrl_reg[CTRL_COMP_REF_BIT];

  // ==========================================================
  // APB slave: one wait state so read data comes from a flop
  wire apb_access = psel && penable;
  wire apb_commit = apb_access && pready;
  wire hit_ctrl = paddr == CTRL_OFFSET;
  wire hit_status = paddr == STATUS_OFFSET;
  wire hit_any = hit_ctrl || hit_status;
  wire [31:0] status_word = {17'h00000, adc_extended_next, ref_ready, jtag_enable, mode_reg,
                             clk_gates, 1'b0, sleeping};
  wire [31:0] read_word = hit_ctrl ? {23'h000000, ctrl_reg} : (hit_status ? status_word : 32'h0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_access && !pready;
      pslverr <= apb_access && !pready && !(hit_ctrl || (hit_status && !pwrite));
      prdata <= (apb_access && !pready && !pwrite) ? read_word : 32'h00000000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (apb_commit && pwrite && hit_ctrl && hit_any) begin
      ctrl_reg <= pwdata[CTRL_W-1:0];
    end
  end

  // ==========================================================
  // External interrupt pins: three flops, change taken when last two agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_s1_reg <= 8'hFF;
      ext_s2_reg <= 8'hFF;
      ext_s3_reg <= 8'hFF;
      ext_filt_reg <= 8'hFF;
    end else begin
      ext_s1_reg <= external_interrupt_lines_n;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      ext_filt_reg <= ext_filt_reg ^ ((ext_s2_reg ~^ ext_s3_reg) & (ext_filt_reg ^ ext_s3_reg));
    end
  end

  // ==========================================================
  // Wake qualification
  wire [7:0] ext_req = ~ext_filt_reg & ext_int_enable;
  wire ext_any = |ext_req;
  wire ext_limited = (|ext_req[3:0]) || (|(ext_req[7:4] & ext_int_level_mode));
  wire wake_idle = ext_any || (|wake_src);
  wire wake_noise = ext_limited || wake_src.two_wire_address_match || wake_src.timer0 ||
                    wake_src.self_program_ready || wake_src.adc_done;
  wire wake_async = ext_limited || wake_src.two_wire_address_match ||
                    (wake_src.timer0 && as0);
  wire wake_deep = ext_limited || wake_src.two_wire_address_match;
  wire wake_hit = (mode_reg == MODE_IDLE) ? wake_idle :
                  (mode_reg == MODE_NOISE) ? wake_noise :
                  ((mode_reg == MODE_PSAVE) || (mode_reg == MODE_XSTBY)) ? wake_async :
                  wake_deep;

  // ==========================================================
  // Mode entry and wake delay
  wire mode_legal = (mode_sel[2:1] != 2'b10);
  wire [2:0] mode_eff = (mode_sel[2:1] == 2'b11 && !crystal_clock_option) ?
                        {1'b0, mode_sel[1:0]} : mode_sel;
  wire [CNT_W-1:0] startup_cyc = (clock_source_select_fuses[3:2] == 2'b00) ? CNT_W'(STARTUP_CYC0) :
                                 (clock_source_select_fuses[3:2] == 2'b01) ? CNT_W'(STARTUP_CYC1) :
                                 (clock_source_select_fuses[3:2] == 2'b10) ? CNT_W'(STARTUP_CYC2) :
                                 CNT_W'(STARTUP_CYC3);
  wire osc_stopped = ((mode_reg == MODE_PDOWN) || (mode_reg == MODE_PSAVE)) && !debug_enable_fuse;
  wire [CNT_W-1:0] wake_cycles = osc_stopped ? startup_cyc :
                                 deep_mode(mode_reg) ? CNT_W'(STBY_WAKE_CYCLES) :
                                 CNT_W'(IDLE_WAKE_CYCLES);

  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      ST_ACTIVE: begin
        if (sleep_instr && sleep_en && mode_legal) begin
          state_next = ST_SLEEP;
          mode_next = mode_eff;
        end
      end
      ST_SLEEP: begin
        if (wake_hit) begin
          state_next = ST_WAKE;
          cnt_next = wake_cycles - CNT_W'(1);
        end
      end
      ST_WAKE: begin
        if (cnt_reg == '0) begin
          state_next = ST_ACTIVE;
        end else begin
          cnt_next = cnt_reg - CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_ACTIVE;
      mode_reg <= MODE_IDLE;
      cnt_reg <= '0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      cnt_reg <= cnt_next;
    end
  end

  // ==========================================================
  // Power outputs, registered from next state so they move with it
  clk_gate_t gates_next;
  assign gates_next = gates_for(state_next, mode_next, as0, debug_enable_fuse);
  wire sleep_next = state_next == ST_SLEEP;
  wire comp_next = comp_en && !(sleep_next && deep_mode(mode_next));
  wire ref_next = brownout_enable_fuse || adc_en || (comp_next && comp_ref);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_gates <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, asy: 1'b1, main_osc: 1'b1,
                     timer_osc: 1'b0};
      sleeping <= 1'b0;
      input_buffer_en <= 1'b1;
      adc_power <= 1'b0;
      comparator_power <= 1'b0;
      ref_power <= 1'b0;
      bod_active <= 1'b0;
      wdt_active <= 1'b0;
    end else begin
      clk_gates <= gates_next;
      sleeping <= sleep_next;
      // Wake pins keep their own buffers; only the general pool is switched
      input_buffer_en <= gates_next.io || gates_next.adc;
      adc_power <= adc_en;
      comparator_power <= comp_next;
      ref_power <= ref_next;
      bod_active <= brownout_enable_fuse;
      wdt_active <= watchdog_enable;
    end
  end

  // ==========================================================
  // Reference start-up and extended first conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_cnt_reg <= '0;
      ref_ready <= 1'b0;
    end else if (!ref_power) begin
      ref_cnt_reg <= '0;
      ref_ready <= 1'b0;
    end else if (ref_cnt_reg < CNT_W'(REF_STARTUP_CYCLES - 1)) begin
      ref_cnt_reg <= ref_cnt_reg + CNT_W'(1);
    end else begin
      ref_ready <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_en_prev_reg <= 1'b0;
      adc_extended_next <= 1'b1;
    end else begin
      adc_en_prev_reg <= adc_en;
      // A re-enable in the same cycle as a start keeps the flag set
      if (adc_en && !adc_en_prev_reg) begin
        adc_extended_next <= 1'b1;
      end else if (adc_conv_start) begin
        adc_extended_next <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Scan port enable and data output
  wire jtag_next = scan_port_enable_fuse && !ctrl_reg[CTRL_SCAN_DIS_BIT];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jtag_enable <= 1'b0;
      tdo_o <= 1'b0;
      tdo_oe <= 1'b0;
    end else begin
      jtag_enable <= jtag_next;
      tdo_o <= tap_tdo_data;
      tdo_oe <= jtag_next && tap_shifting;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  wire in_stby = state_reg == ST_SLEEP && mode_reg == MODE_STBY;
  wire in_xstby = state_reg == ST_SLEEP && mode_reg == MODE_XSTBY;

  a_stby_wake_six: assert property (in_stby && wake_hit |=>
                                    !clk_gates.cpu [*6] ##1 clk_gates.cpu)
    else $error("standby wake not six cycles");
  a_xstby_wake_six: assert property (in_xstby && wake_hit |->
                                     ##7 clk_gates.cpu && !sleeping)
    else $error("extended standby wake not six cycles");
  a_stby_osc_on: assert property (in_stby |->
                                  clk_gates.main_osc && !clk_gates.io && !clk_gates.asy)
    else $error("standby gating wrong");
  a_xstby_async: assert property (in_xstby |-> clk_gates.main_osc && clk_gates.asy == as0)
    else $error("extended standby gating wrong");
  a_cpu_stopped: assert property (sleeping |-> !clk_gates.cpu && !clk_gates.flash)
    else $error("cpu clock runs in sleep");
  a_pdown_dbg_osc: assert property (state_reg == ST_SLEEP && mode_reg == MODE_PDOWN
                                    |-> clk_gates.main_osc == debug_enable_fuse)
    else $error("power-down oscillator wrong");
  a_buffer_gated: assert property (sleeping && !clk_gates.io && !clk_gates.adc
                                   |-> !input_buffer_en)
    else $error("input buffers on");
  a_comp_deep_off: assert property (sleeping && deep_mode(mode_reg) |-> !comparator_power)
    else $error("comparator powered in deep sleep");
  a_ref_follow: assert property ($rose(adc_en) |=> ref_power)
    else $error("reference not powered for converter");
  a_adc_kept: assert property (sleeping && adc_en && $past(adc_en) |-> adc_power)
    else $error("converter dropped in sleep");
  a_adc_extended: assert property ($rose(adc_en) |=> adc_extended_next)
    else $error("extended conversion flag missing");
  a_tdo_float: assert property (!tap_shifting |=> !tdo_oe)
    else $error("data output driven while idle");
  a_jtag_off: assert property (ctrl_reg[CTRL_SCAN_DIS_BIT] |=> !jtag_enable)
    else $error("scan port not disabled");
  a_wake_resume: assert property (state_reg == ST_WAKE && cnt_reg == '0
                                  |=> clk_gates.io && input_buffer_en)
    else $error("clocks not restored");
  a_bod_wdt: assert property (sleeping |->
                              bod_active == brownout_enable_fuse && wdt_active == watchdog_enable)
    else $error("brown-out or watchdog dropped");

  c_stby_round: cover property (in_stby ##1 !sleeping [*6]);
  c_pdown_wake: cover property (state_reg == ST_SLEEP && mode_reg == MODE_PDOWN ##1 state_reg == ST_WAKE);
  c_idle_enter: cover property (sleeping && mode_reg == MODE_IDLE);
  c_ref_ready: cover property ($rose(ref_ready));
endmodule // sleep_ctrl

// file: src/sleep_ctrl_pkg.sv
package sleep_ctrl_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam int ADDR_W = 8;
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SLEEP_EN_BIT = 3;
  localparam int CTRL_SCAN_DIS_BIT = 4;
  localparam int CTRL_ASYNC_SEL_BIT = 5;
  localparam int CTRL_ADC_EN_BIT = 6;
  localparam int CTRL_COMP_EN_BIT = 7;
  localparam int CTRL_COMP_REF_BIT = 8;
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;
  // ==========================================================
  // Sleep mode encodings
  localparam logic [2:0] MODE_IDLE = 3'h0;
  localparam logic [2:0] MODE_NOISE = 3'h1;
  localparam logic [2:0] MODE_PDOWN = 3'h2;
  localparam logic [2:0] MODE_PSAVE = 3'h3;
  localparam logic [2:0] MODE_STBY = 3'h6;
  localparam logic [2:0] MODE_XSTBY = 3'h7;
  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STBY_WAKE_CYCLES = 6;
  localparam int IDLE_WAKE_CYCLES = 1;
  localparam int REF_STARTUP_NS = 40000;
  localparam int REF_STARTUP_CYCLES = (REF_STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 17;
  // ==========================================================
  // Clock domain enables
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
    logic timer_osc;
  } clk_gate_t;
  // Wake request sources from the peripherals
  typedef struct packed {
    logic two_wire_address_match;
    logic timer0;
    logic self_program_ready;
    logic adc_done;
    logic other_io;
  } wake_src_t;
endpackage
